// [design/cpc_charger_protection_config.sv]
`timescale 1ns/1ps
`default_nettype none
module cpc_charger_protection_config #(
  parameter int unsigned DEG0 = cpc_pkg::DEG0_CYC,
  parameter int unsigned DEG1 = cpc_pkg::DEG1_CYC,
  parameter int unsigned DEG2 = cpc_pkg::DEG2_CYC,
  parameter int unsigned DEG3 = cpc_pkg::DEG3_CYC,
  parameter int unsigned CYC0 = cpc_pkg::CYC0_CYC,
  parameter int unsigned CYC1 = cpc_pkg::CYC1_CYC,
  parameter int unsigned CYC2 = cpc_pkg::CYC2_CYC,
  parameter int unsigned CYC3 = cpc_pkg::CYC3_CYC,
  parameter int unsigned BLANK = cpc_pkg::BLANK_CYC,
  parameter int unsigned RELEASE = cpc_pkg::RELEASE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Byte register port behind the serial host interface
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Analog comparator levels, asynchronous to clk_i
  input wire logic adapter_present_i,
  input wire logic input_overshoot_i,
  input wire logic system_droop_i,
  input wire logic fixed_oc_trip_i,
  input wire logic input_oc_trip_i,
  input wire logic discharge_oc_trip_i,
  // Limit codes from the pin converter and the limit register
  input wire logic [7:0] limit_setting_pin_i,
  input wire logic [7:0] input_limit_register_i,
  input wire logic input_sense_resistor_sel_i,
  // Results
  output logic [7:0] input_limit_o,
  output cpc_pkg::cpc_thresh_s thresh_o,
  output logic burst_active_o,
  output logic converter_en_o
);
  import cpc_pkg::*;

  // Picks one of four cycle counts by a two-bit code
  function automatic logic [31:0] pick4(input logic [1:0] code, input int unsigned c0,
                                        input int unsigned c1, input int unsigned c2,
                                        input int unsigned c3);
    unique case (code)
      2'b00: pick4 = 32'(c0);
      2'b01: pick4 = 32'(c1);
      2'b10: pick4 = 32'(c2);
      2'b11: pick4 = 32'(c3);
    endcase
  endfunction

  // Percentage figure for a level bit
  function automatic logic [7:0] pct(input logic lvl);
    pct = lvl ? PCT_HIGH : PCT_LOW;
  endfunction

  cpc_burst_s burst;
  cpc_prot_s prot;
  logic [15:0] opt3;
  cpc_burst_e state;
  cpc_burst_e next_state;

  // Synchroniser stages; only the second stage is read by logic
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic adapter_prev;
  logic adapter_removed;
  logic s_adapter;
  logic s_ovs;
  logic s_droop;
  logic s_fixed;
  logic s_acoc;
  logic s_batoc;

  logic wr_hi;
  logic clr_ovld;
  logic clr_relax;
  logic trigger;
  logic burst_allowed;
  logic enter_expired;
  logic phase_expired;
  logic phase_restart;
  logic blank_expired;
  logic release_expired;
  logic acoc_fault;
  logic [31:0] enter_limit;
  logic [31:0] phase_limit;

  // Two flops on every analog level before use
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 6'h00;
      sync2 <= 6'h00;
    end else begin
      sync1 <= {adapter_present_i, input_overshoot_i, system_droop_i,
                fixed_oc_trip_i, input_oc_trip_i, discharge_oc_trip_i};
      sync2 <= sync1;
    end
  end

  assign s_adapter = sync2[5];
  assign s_ovs = sync2[4];
  assign s_droop = sync2[3];
  assign s_fixed = sync2[2];
  assign s_acoc = sync2[1];
  assign s_batoc = sync2[0];

  // Remembers the adapter level to spot its falling edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      adapter_prev <= 1'b0;
    end else begin
      adapter_prev <= s_adapter;
    end
  end

  assign adapter_removed = adapter_prev && !s_adapter;
  assign wr_hi = reg_wr_i && (reg_addr_i == ADDR_OPT2_HI);
  // Writing one to a status flag does nothing; only a zero ends the cycle
  // (R06) overload clear write
  assign clr_ovld = wr_hi && !reg_wdata_i[BIT_OVLD_FLAG];
  // (R07) relax clear write
  assign clr_relax = wr_hi && !reg_wdata_i[BIT_RELAX_FLAG];

  // Burst control fields; status flag bits are not stored, they mirror state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      burst <= cpc_burst_s'(RST_OPT2[15:8]);
    end else begin
      if (wr_hi) begin
        // (R01) deglitch code written
        burst.ovld_deg <= reg_wdata_i[7:6];
        // (R02) overshoot enable written
        burst.ovs_en <= reg_wdata_i[5];
        // (R03) droop enable written
        burst.droop_en <= reg_wdata_i[4];
        // (R08) cycle code written
        burst.tmax <= reg_wdata_i[1:0];
      end
      // (R05) removal clears enables
      if (adapter_removed) begin
        burst.ovs_en <= 1'b0;
        burst.droop_en <= 1'b0;
      end
      burst.ovld_flag <= (next_state == BURST_OVLD);
      burst.relax_flag <= (next_state == BURST_RELAX);
    end
  end

  // Protection byte and the following option register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prot <= cpc_prot_s'(RST_OPT2[7:0]);
      opt3 <= RST_OPT3;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_OPT2_LO) begin
        prot <= cpc_prot_s'(reg_wdata_i);
      end
      if (reg_addr_i == ADDR_OPT3_LO) begin
        opt3[7:0] <= reg_wdata_i;
      end
      if (reg_addr_i == ADDR_OPT3_HI) begin
        opt3[15:8] <= reg_wdata_i;
      end
    end
  end

  // Register reads answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          ADDR_OPT2_LO: reg_rdata_o <= prot;
          ADDR_OPT2_HI: reg_rdata_o <= burst;
          ADDR_OPT3_LO: reg_rdata_o <= opt3[7:0];
          ADDR_OPT3_HI: reg_rdata_o <= opt3[15:8];
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // (R04) both enables off blocks burst
  assign burst_allowed = burst.ovs_en || burst.droop_en;
  // (R02) overshoot trigger path
  // (R03) droop trigger path
  assign trigger = (burst.ovs_en && s_ovs) || (burst.droop_en && s_droop);

  // (R01) deglitch length by code
  assign enter_limit = pick4(burst.ovld_deg, DEG0, DEG1, DEG2, DEG3);
  // (R08) cycle length by code
  assign phase_limit = pick4(burst.tmax, CYC0, CYC1, CYC2, CYC3);

  // Overload must persist for the deglitch time before a burst starts
  cpc_timer u_enter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(trigger && (state == BURST_IDLE)),
    .clr_i(1'b0),
    .limit_i(enter_limit),
    .expired_o(enter_expired)
  );

  // One timer serves both phases; it restarts at each phase change
  assign phase_restart = (next_state != state);

  cpc_timer u_phase (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state != BURST_IDLE),
    .clr_i(phase_restart),
    .limit_i(phase_limit),
    .expired_o(phase_expired)
  );

  // Burst sequencing; a software clear beats a timed phase change
  always_comb begin
    next_state = state;
    unique case (state)
      BURST_IDLE: begin
        if (burst_allowed && enter_expired) begin
          next_state = BURST_OVLD;
        end
      end
      // (R19) overload then relax
      BURST_OVLD: begin
        if (!burst_allowed || clr_ovld) begin
          next_state = BURST_IDLE;
        end else if (phase_expired) begin
          next_state = BURST_RELAX;
        end
      end
      // (R19) relax then repeat
      BURST_RELAX: begin
        if (!burst_allowed || clr_relax) begin
          next_state = BURST_IDLE;
        end else if (phase_expired) begin
          next_state = trigger ? BURST_OVLD : BURST_IDLE;
        end
      end
      default: next_state = BURST_IDLE;
    endcase
  end

  // Burst state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= BURST_IDLE;
      burst_active_o <= 1'b0;
    end else begin
      state <= next_state;
      burst_active_o <= (next_state != BURST_IDLE);
    end
  end

  // (R14) blanking before input fault
  cpc_timer u_blank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(prot.acoc_en && s_acoc && !acoc_fault),
    .clr_i(1'b0),
    .limit_i(32'(BLANK)),
    .expired_o(blank_expired)
  );

  // (R15) clean time before restart
  cpc_timer u_release (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(acoc_fault && !s_acoc),
    .clr_i(1'b0),
    .limit_i(32'(RELEASE)),
    .expired_o(release_expired)
  );

  // Input overcurrent fault; disabling the protection drops it at once
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acoc_fault <= 1'b0;
    end else if (!prot.acoc_en) begin
      acoc_fault <= 1'b0;
    end else if (blank_expired) begin
      // (R14) fault after blanking
      acoc_fault <= 1'b1;
    end else if (release_expired) begin
      // (R15) non latching release
      acoc_fault <= 1'b0;
    end
  end

  // Converter gate; the fixed comparator acts without any deglitch
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      converter_en_o <= 1'b0;
    end else begin
      // (R13) fixed trip stops converter
      // (R17) discharge trip stops converter
      converter_en_o <= !s_fixed && !acoc_fault && !(prot.batoc_en && s_batoc);
    end
  end

  // Effective input current limit
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      input_limit_o <= 8'h00;
    end else if (prot.ext_lim_en && (limit_setting_pin_i < input_limit_register_i)) begin
      // (R09) lower of pin and register
      input_limit_o <= limit_setting_pin_i;
    end else begin
      // (R09) register alone
      input_limit_o <= input_limit_register_i;
    end
  end

  // Threshold settings for the analog comparators
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thresh_o <= '0;
    end else begin
      // (R10) monitor direction
      thresh_o.mon_charge <= prot.mon_dir;
      // (R11) low switch threshold
      thresh_o.low_sw_mv <= prot.low_sw_sel ? MV_LOWSW_1 : MV_LOWSW_0;
      // (R12) fixed threshold by resistor
      unique case ({prot.fixed_sel, input_sense_resistor_sel_i})
        2'b00: thresh_o.fixed_oc_mv <= MV_FIX_00;
        2'b01: thresh_o.fixed_oc_mv <= MV_FIX_01;
        2'b10: thresh_o.fixed_oc_mv <= MV_FIX_10;
        2'b11: thresh_o.fixed_oc_mv <= MV_FIX_11;
      endcase
      // (R16) input overcurrent level
      thresh_o.acoc_pct <= pct(prot.acoc_lvl);
      // (R18) discharge overcurrent level
      thresh_o.batoc_pct <= pct(prot.batoc_lvl);
    end
  end

endmodule // cpc_charger_protection_config
`default_nettype wire

// [design/cpc_pkg.sv]
// Operation
// (R01) Overload deglitch code 00/01/10/11 selects 1/2/5/10 ms; resets to 00.
// (R02) Input-overshoot enable lets burst mode start on input overshoot; resets clear.
// (R03) System-droop enable lets burst mode start on system droop; resets clear.
// (R04) With both burst trigger enables clear, burst mode stays fully off.
// (R05) Adapter removal clears both burst trigger enables, overriding software.
// (R06) Overload flag is one during overload cycle; writing zero ends it.
// (R07) Relax flag is one during relax cycle; writing zero ends it.
// (R08) Cycle time code 00/01/10/11 selects 20/40/80/1000 ms; resets to 00.
// (R09) External limit enable picks register limit alone, or lower of pin and register.
// (R10) Monitor direction bit: zero reports discharge current, one reports charge current.
// (R11) Low switch overcurrent threshold is 210 mV at zero, 150 mV at one.
// (R12) Fixed input overcurrent threshold: 280/200 mV or 150/100 mV by resistor select.
// (R13) Fixed input overcurrent trip stops converter at once, resumes on release.
// (R14) Enabled input overcurrent lasting past 250 us blanking disables converter.
// (R15) Input overcurrent fault clears after 250 ms clean, converter restarts.
// (R16) Input overcurrent level: 133 percent at zero, 200 percent at one.
// (R17) Enabled discharge overcurrent above threshold disables the converter.
// (R18) Discharge overcurrent level: 133 percent at zero, 200 percent at one.
// (R19) Burst mode alternates overload and relax cycles, flags follow each transition.
package cpc_pkg;

  // Register byte addresses on the serial register port
  localparam logic [7:0] ADDR_OPT2_LO = 8'h32;
  localparam logic [7:0] ADDR_OPT2_HI = 8'h33;
  localparam logic [7:0] ADDR_OPT3_LO = 8'h34;
  localparam logic [7:0] ADDR_OPT3_HI = 8'h35;

  // Reset values
  localparam logic [15:0] RST_OPT2 = 16'h00B7;
  localparam logic [15:0] RST_OPT3 = 16'h0434;

  // Field positions in the upper option byte
  localparam int unsigned BIT_OVLD_FLAG = 3;
  localparam int unsigned BIT_RELAX_FLAG = 2;

  // Clock rate and timing figures in their own units
  localparam longint unsigned CLK_HZ = 25_000_000;
  localparam longint unsigned T_DEG0_MS = 1;
  localparam longint unsigned T_DEG1_MS = 2;
  localparam longint unsigned T_DEG2_MS = 5;
  localparam longint unsigned T_DEG3_MS = 10;
  localparam longint unsigned T_CYC0_MS = 20;
  localparam longint unsigned T_CYC1_MS = 40;
  localparam longint unsigned T_CYC2_MS = 80;
  localparam longint unsigned T_CYC3_MS = 1000;
  localparam longint unsigned T_BLANK_US = 250;
  localparam longint unsigned T_RELEASE_MS = 250;

  // Derived cycle counts
  localparam int unsigned DEG0_CYC = int'(T_DEG0_MS * CLK_HZ / 1000);
  localparam int unsigned DEG1_CYC = int'(T_DEG1_MS * CLK_HZ / 1000);
  localparam int unsigned DEG2_CYC = int'(T_DEG2_MS * CLK_HZ / 1000);
  localparam int unsigned DEG3_CYC = int'(T_DEG3_MS * CLK_HZ / 1000);
  localparam int unsigned CYC0_CYC = int'(T_CYC0_MS * CLK_HZ / 1000);
  localparam int unsigned CYC1_CYC = int'(T_CYC1_MS * CLK_HZ / 1000);
  localparam int unsigned CYC2_CYC = int'(T_CYC2_MS * CLK_HZ / 1000);
  localparam int unsigned CYC3_CYC = int'(T_CYC3_MS * CLK_HZ / 1000);
  localparam int unsigned BLANK_CYC = int'(T_BLANK_US * CLK_HZ / 1_000_000);
  localparam int unsigned RELEASE_CYC = int'(T_RELEASE_MS * CLK_HZ / 1000);

  // Thresholds reported to the analog side
  localparam logic [8:0] MV_LOWSW_0 = 9'h0D2;
  localparam logic [8:0] MV_LOWSW_1 = 9'h096;
  localparam logic [8:0] MV_FIX_00 = 9'h118;
  localparam logic [8:0] MV_FIX_01 = 9'h0C8;
  localparam logic [8:0] MV_FIX_10 = 9'h096;
  localparam logic [8:0] MV_FIX_11 = 9'h064;
  localparam logic [7:0] PCT_LOW = 8'h85;
  localparam logic [7:0] PCT_HIGH = 8'hC8;

  // Upper option byte: burst mode controls, MSB first
  typedef struct packed {
    logic [1:0] ovld_deg;
    logic ovs_en;
    logic droop_en;
    logic ovld_flag;
    logic relax_flag;
    logic [1:0] tmax;
  } cpc_burst_s;

  // Lower option byte: protection controls, MSB first
  typedef struct packed {
    logic ext_lim_en;
    logic mon_dir;
    logic low_sw_sel;
    logic fixed_sel;
    logic acoc_en;
    logic acoc_lvl;
    logic batoc_en;
    logic batoc_lvl;
  } cpc_prot_s;

  // Settings handed to the analog side
  typedef struct packed {
    logic mon_charge;
    logic [8:0] low_sw_mv;
    logic [8:0] fixed_oc_mv;
    logic [7:0] acoc_pct;
    logic [7:0] batoc_pct;
  } cpc_thresh_s;

  typedef enum logic [1:0] {
    BURST_IDLE = 2'b00,
    BURST_OVLD = 2'b01,
    BURST_RELAX = 2'b10
  } cpc_burst_e;

endpackage

// [design/cpc_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// Counts cycles while run_i is high; expired_o rises once limit_i is reached.
module cpc_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic clr_i,
  input wire logic [31:0] limit_i,
  output logic expired_o
);

  logic [31:0] count;

  // Count restarts whenever the watched condition drops or a restart is asked
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 32'h0000_0000;
    end else if (!run_i || clr_i) begin
      count <= 32'h0000_0000;
    end else if (count < limit_i) begin
      count <= count + 32'h0000_0001;
    end
  end

  // Registered so the expiry is one clean level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      expired_o <= 1'b0;
    end else begin
      expired_o <= run_i && !clr_i && (count + 32'h0000_0001 >= limit_i);
    end
  end

endmodule // cpc_timer
`default_nettype wire

// [sim/cpc_charger_protection_config_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module cpc_charger_protection_config_bench;
  import cpc_pkg::*;
  // Short counts keep the run brief; expectations use the same values
  localparam int DG[4] = '{4, 5, 6, 7};
  localparam int CY[4] = '{10, 12, 14, 16};
  localparam int BLK = 8;
  localparam int REL = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, input_limit_o;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, burst_active_o, converter_en_o;
  logic adapter_present_i = 1'b1;
  logic input_overshoot_i = 1'b0;
  logic system_droop_i = 1'b0;
  logic fixed_oc_trip_i = 1'b0;
  logic input_oc_trip_i = 1'b0;
  logic discharge_oc_trip_i = 1'b0;
  logic [7:0] limit_setting_pin_i = 8'h00;
  logic [7:0] input_limit_register_i = 8'h00;
  logic input_sense_resistor_sel_i = 1'b0;
  cpc_thresh_s thresh_o;
  logic [31:0] v;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 65350;
  int cyc = 0;
  int r[4];
  int l[4];
  cpc_charger_protection_config #(.DEG0(DG[0]), .DEG1(DG[1]), .DEG2(DG[2]), .DEG3(DG[3]),
    .CYC0(CY[0]), .CYC1(CY[1]), .CYC2(CY[2]), .CYC3(CY[3]), .BLANK(BLK), .RELEASE(REL))
  i_cpc_charger_protection_config (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .adapter_present_i(adapter_present_i), .input_overshoot_i(input_overshoot_i),
    .system_droop_i(system_droop_i), .fixed_oc_trip_i(fixed_oc_trip_i),
    .input_oc_trip_i(input_oc_trip_i), .discharge_oc_trip_i(discharge_oc_trip_i),
    .limit_setting_pin_i(limit_setting_pin_i), .input_limit_register_i(input_limit_register_i),
    .input_sense_resistor_sel_i(input_sense_resistor_sel_i), .input_limit_o(input_limit_o),
    .thresh_o(thresh_o), .burst_active_o(burst_active_o), .converter_en_o(converter_en_o));
  cpc_host i_cpc_host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
  // 40 ns period
  always #20 clk_i = ~clk_i;
  // Hang guard, far above the several hundred cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_cpc_host.read_reg(a, d);
    check("register", e, d);
  endtask
  // Threshold codes worked out from the option byte and resistor select
  function automatic cpc_thresh_s exp_thr(input logic [7:0] p, input logic rs);
    cpc_thresh_s t;
    t.mon_charge = p[6];
    t.low_sw_mv = p[5] ? 9'h096 : 9'h0D2;
    t.fixed_oc_mv = p[4] ? (rs ? 9'h064 : 9'h096) : (rs ? 9'h0C8 : 9'h118);
    t.acoc_pct = p[2] ? 8'hC8 : 8'h85;
    t.batoc_pct = p[0] ? 8'hC8 : 8'h85;
    return t;
  endfunction
  function automatic logic [7:0] exp_lim(input logic en, input logic [7:0] p, input logic [7:0] g);
    return (en && p < g) ? p : g;
  endfunction
  // Raises one trigger, times the burst start, drops it and times the burst length
  task automatic run_burst(input logic dr, output int rise, output int len);
    rise = 0;
    len = 0;
    input_overshoot_i = ~dr;
    system_droop_i = dr;
    while (burst_active_o !== 1'b1 && rise < 300) begin
      @(negedge clk_i);
      rise++;
    end
    input_overshoot_i = 1'b0;
    system_droop_i = 1'b0;
    while (burst_active_o === 1'b1 && len < 300) begin
      @(negedge clk_i);
      len++;
    end
  endtask
  // Holds one trip pin (0 fixed, 1 input, 2 discharge), checks during and after
  task automatic trip(input int w, input int hold, input logic e1, input int gap, input logic e2);
    {fixed_oc_trip_i, input_oc_trip_i, discharge_oc_trip_i} = 3'b100 >> w;
    repeat (hold) @(negedge clk_i);
    check("converter during trip", e1, converter_en_o);
    {fixed_oc_trip_i, input_oc_trip_i, discharge_oc_trip_i} = 3'b000;
    repeat (gap) @(negedge clk_i);
    check("converter after trip", e2, converter_en_o);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    rchk(8'h32, 8'hB7);
    rchk(8'h33, 8'h00);
    rchk(8'h34, 8'h34);
    rchk(8'h35, 8'h04);
    rchk(8'h36, 8'h00);
    check("thresholds", exp_thr(8'hB7, 1'b0), thresh_o);
    $display("Test reset values done");
    // Random option bytes; the first four force every fixed threshold pair
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      if (i < 4) v[4] = i[0];
      if (i < 4) v[8] = i[1];
      input_sense_resistor_sel_i = v[8];
      limit_setting_pin_i = v[23:16];
      input_limit_register_i = v[31:24];
      i_cpc_host.write_reg(8'h32, v[7:0]);
      i_cpc_host.write_reg(8'h35, v[15:8]);
      rchk(8'h35, v[15:8]);
      rchk(8'h32, v[7:0]);
      check("thresholds", exp_thr(v[7:0], v[8]), thresh_o);
      check("input limit", exp_lim(v[7], v[23:16], v[31:24]), input_limit_o);
    end
    $display("Test option bytes done");
    // Triggers present but no enable: burst stays off, status bits cannot be set
    input_overshoot_i = 1'b1;
    system_droop_i = 1'b1;
    i_cpc_host.write_reg(8'h33, 8'hCF);
    repeat (30) @(negedge clk_i);
    check("burst", 1'b0, burst_active_o);
    rchk(8'h33, 8'hC3);
    i_cpc_host.write_reg(8'h33, 8'h20);
    input_overshoot_i = 1'b0;
    repeat (30) @(negedge clk_i);
    check("burst", 1'b0, burst_active_o);
    system_droop_i = 1'b0;
    // Start delay per deglitch code, burst length per cycle time code
    for (int k = 0; k < 4; k++) begin
      i_cpc_host.write_reg(8'h33, {k[1:0], 6'h20});
      run_burst(1'b0, r[k], l[k]);
      check("deglitch delay", DG[k] + 3, r[k]);
    end
    for (int k = 0; k < 4; k++) begin
      i_cpc_host.write_reg(8'h33, {6'h04, k[1:0]});
      run_burst(1'b1, r[k], l[k]);
      check("burst length", 2 * CY[k] + 2, l[k]);
    end
    $display("Test burst timing done");
    // Clearing each flag ends its phase; trigger held so a fresh burst follows
    input_overshoot_i = 1'b1;
    i_cpc_host.write_reg(8'h33, 8'h23);
    run_burst_wait();
    repeat (2 * CY[3] + 2) @(negedge clk_i);
    rchk(8'h33, 8'h2B);
    i_cpc_host.write_reg(8'h33, 8'h23);
    @(negedge clk_i);
    check("burst", 1'b0, burst_active_o);
    run_burst_wait();
    repeat (CY[3] + 2) @(negedge clk_i);
    rchk(8'h33, 8'h27);
    i_cpc_host.write_reg(8'h33, 8'h23);
    @(negedge clk_i);
    check("burst", 1'b0, burst_active_o);
    input_overshoot_i = 1'b0;
    // Adapter removal wipes both enables
    i_cpc_host.write_reg(8'h33, 8'h30);
    adapter_present_i = 1'b0;
    repeat (4) @(negedge clk_i);
    adapter_present_i = 1'b1;
    rchk(8'h33, 8'h00);
    $display("Test flags and adapter done");
    i_cpc_host.write_reg(8'h32, 8'hB7);
    trip(0, 5, 1'b0, 5, 1'b1);
    trip(2, 5, 1'b0, 5, 1'b1);
    trip(1, 20, 1'b1, 2, 1'b1);
    i_cpc_host.write_reg(8'h32, 8'hBD);
    trip(2, 8, 1'b1, 2, 1'b1);
    trip(1, BLK - 3, 1'b1, 2, 1'b1);
    trip(1, BLK + 6, 1'b0, REL - 6, 1'b0);
    repeat (12) @(negedge clk_i);
    check("converter restart", 1'b1, converter_en_o);
    $display("Test protection done");
    finish_test();
  end
  // Bounded wait for the burst to begin
  task automatic run_burst_wait();
    for (int n = 0; n < 60 && burst_active_o !== 1'b1; n++) @(negedge clk_i);
  endtask
endmodule // cpc_charger_protection_config_bench
`default_nettype wire

// [sim/cpc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin-level watcher; trips and triggers pass a two-flop sync inside, hence the lags
module cpc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic input_overshoot_i,
  input wire logic system_droop_i,
  input wire logic fixed_oc_trip_i,
  input wire logic input_oc_trip_i,
  input wire logic discharge_oc_trip_i,
  input wire logic [7:0] limit_setting_pin_i,
  input wire logic [7:0] input_limit_register_i,
  input wire logic input_sense_resistor_sel_i,
  input wire logic [7:0] input_limit_o,
  input wire cpc_pkg::cpc_thresh_s thresh_o,
  input wire logic burst_active_o,
  input wire logic converter_en_o
);
  import cpc_pkg::*;
  logic any_trip;
  // Any cause that may stop the converter
  assign any_trip = fixed_oc_trip_i | input_oc_trip_i | discharge_oc_trip_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_fixed_trip_stop: assert property (fixed_oc_trip_i [*4] |=> !converter_en_o)
    else $error("converter ran through a fixed trip");
  a_resume_released: assert property ($rose(converter_en_o) |-> !$past(fixed_oc_trip_i, 3))
    else $error("converter resumed with fixed trip present");
  a_stop_has_cause: assert property ($fell(converter_en_o) |->
    $past(any_trip, 3) || $past(any_trip, 4)) else $error("converter stopped without a trip");
  a_burst_has_trigger: assert property ($rose(burst_active_o) |->
    $past(input_overshoot_i || system_droop_i, 4)) else $error("burst began without trigger");
  a_low_sw_code: assert property (!$past(rst_i) |-> thresh_o.low_sw_mv inside {9'h0D2, 9'h096})
    else $error("low switch threshold out of set");
  a_fixed_oc_pair: assert property (!$past(rst_i) |->
    thresh_o.fixed_oc_mv inside {9'h118, 9'h0C8, 9'h096, 9'h064} &&
    (thresh_o.fixed_oc_mv inside {9'h0C8, 9'h064}) == $past(input_sense_resistor_sel_i))
    else $error("fixed threshold ignores resistor select");
  a_acoc_pct_set: assert property (!$past(rst_i) |-> thresh_o.acoc_pct inside {8'h85, 8'hC8})
    else $error("input overcurrent percent out of set");
  a_batoc_pct_set: assert property (!$past(rst_i) |-> thresh_o.batoc_pct inside {8'h85, 8'hC8})
    else $error("discharge percent out of set");
  a_limit_pick: assert property (!$past(rst_i) |->
    input_limit_o <= $past(input_limit_register_i) && (input_limit_o == $past(input_limit_register_i)
    || input_limit_o == $past(limit_setting_pin_i))) else $error("input limit from wrong source");
endmodule // cpc_chk
bind cpc_charger_protection_config cpc_chk i_cpc_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .input_overshoot_i(input_overshoot_i),
  .system_droop_i(system_droop_i),
  .fixed_oc_trip_i(fixed_oc_trip_i),
  .input_oc_trip_i(input_oc_trip_i),
  .discharge_oc_trip_i(discharge_oc_trip_i),
  .limit_setting_pin_i(limit_setting_pin_i),
  .input_limit_register_i(input_limit_register_i),
  .input_sense_resistor_sel_i(input_sense_resistor_sel_i),
  .input_limit_o(input_limit_o),
  .thresh_o(thresh_o),
  .burst_active_o(burst_active_o),
  .converter_en_o(converter_en_o)
);
`default_nettype wire

// [sim/cpc_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Stands for the serial host; the bench calls its tasks
module cpc_host (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o
);
  // Idle bus at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // host writes one byte with a single-cycle strobe
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d; // Released data never keeps its last value
  endtask
  // Strobe held until the answer is seen, bounded so a dead port cannot hang
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (reg_rvalid_i !== 1'b1 && n < 8);
    d = (reg_rvalid_i === 1'b1) ? reg_rdata_i : 8'hXX;
    reg_rd_o = 1'b0;
  endtask
endmodule // cpc_host
`default_nettype wire
